// file: hw/pm_regs.sv
// transmit fifo information and power management control registers
`timescale 1ns/100ps
`include "pm_regs_defs.svh"

module pm_regs #(
  parameter int unsigned WAKE_PULSE_CYCLES = `WAKE_PULSE_CYC,
  parameter int unsigned READY_CYCLES      = `READY_CYC
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  // register bus
  input  wire pm_regs_pkg::apb_req_s  apb_req,
  output pm_regs_pkg::apb_rsp_s       apb_rsp,
  // transmit fifo levels
  input  wire logic [7:0]             tx_status_used_dwords,
  input  wire logic [15:0]            tx_data_free_bytes,
  // wake detectors
  input  wire logic                   wake_frame_event,
  input  wire logic                   energy_detect_event,
  // phy and power control
  output logic                        phy_reset,
  output logic [1:0]                  power_state,
  output logic                        device_ready,
  // wake signalling
  output logic                        wake_event_interrupt,
  output logic                        wake_event_output,
  output logic                        wake_event_output_oe
);
  import pm_regs_pkg::*;

  localparam int unsigned PHY_CYC = `PHY_RESET_REQUEST_CYC;
  localparam int unsigned PW = $clog2(PHY_CYC + 1);
  localparam int unsigned RW = $clog2(READY_CYCLES + 1);

  // address match helper, used for every register
  function automatic logic hit(input logic [`APB_AW-1:0] a,
                               input logic [`APB_AW-1:0] offs);
    hit = (a == offs);
  endfunction

  // bus phase decode
  wire setup      = apb_req.psel & ~apb_req.penable;
  wire access     = apb_req.psel & apb_req.penable & apb_rsp.pready;
  wire read_done  = access & ~apb_req.pwrite;
  wire write_done = access & apb_req.pwrite;

  // register selects
  wire hit_tx = hit(apb_req.paddr, `TX_INFO_OFFS);
  wire hit_pm = hit(apb_req.paddr, `PM_CTRL_OFFS);
  wire hit_bt = hit(apb_req.paddr, `BYTE_ORDER_TEST_OFFS);
  wire mapped = hit_tx | hit_pm | hit_bt;

  // write data fields
  wire [31:0] wd      = apb_req.pwdata;
  wire [1:0]  wd_mode = wd[`POWER_STATE_SELECT_LSB+1:`POWER_STATE_SELECT_LSB];
  wire [1:0]  wd_wups = wd[`WUPS_LSB+1:`WUPS_LSB];

  // sequencer state
  rdy_state_e   state_reg;      // settling, ready or asleep
  rdy_state_e   state_next;
  logic [RW-1:0] rdy_cnt_reg;   // settle time counter
  logic [RW-1:0] rdy_cnt_next;
  logic          read_seen_reg; // a read happened since wake
  logic          read_seen_next;

  // transmit information snapshot
  logic [7:0]  txs_reg;         // tx status dwords used
  logic [15:0] txd_reg;         // tx data bytes free

  // power management fields
  pm_state_e   power_state_select_reg;     // current power state
  pm_state_e   power_state_select_next;
  logic          phy_reset_request_reg;   // phy held in reset
  logic          phy_reset_request_next;
  logic [PW-1:0] phy_cnt_reg;   // phy reset cycles left
  logic [PW-1:0] phy_cnt_next;
  logic        wf_en_reg;       // wake frame event enable
  logic        energy_detect_event_enable_reg;       // energy detect enable
  logic        drv_type_reg;    // 1 push-pull, 0 open-drain
  logic        pulse_sel_reg;   // 1 pulsed, 0 static
  logic        pol_reg;         // 1 active high
  logic        out_en_reg;      // wake pin enable
  logic [1:0]  wups_reg;        // sticky wake causes
  logic [1:0]  wups_next;

  // bus answer and pin registers
  apb_rsp_s    rsp_reg;
  apb_rsp_s    rsp_next;
  logic        int_reg;
  logic        wout_reg;
  logic        wout_next;
  logic        woe_reg;
  logic        woe_next;
  logic        rdy_out_reg;     // ready flag, flopped for the port

  wire ready = (state_reg == ST_READY);

  // power control writes act only once read and ready
  // read before write
  wire wr_ok  = write_done & read_seen_reg & ready;
  wire pm_wr  = wr_ok & hit_pm;

  // the wake write must work while asleep, so it skips the read gate
  // wake on test write
  wire wake_wr = write_done & hit_bt & (state_reg == ST_SLEEP);

  // only the two real low-power codes start a sleep; 11b is dropped
  // reserved code ignored
  wire sleep_req = pm_wr & ((wd_mode == PM_D1) | (wd_mode == PM_D2));

  // readiness sequencer
  always_comb
  begin
    state_next   = state_reg;
    rdy_cnt_next = rdy_cnt_reg;
    case (state_reg)
      // count up through the stabilising time
      ST_SETTLE:
      begin
        if (rdy_cnt_reg >= RW'(READY_CYCLES - 1))
        begin
          state_next   = ST_READY;
          rdy_cnt_next = '0;
        end
        else
          rdy_cnt_next = rdy_cnt_reg + 1'b1;
      end
      // normal operation until a sleep is asked for
      ST_READY:
      begin
        if (sleep_req)
          state_next = ST_SLEEP;
      end
      // reduced power until the wake write
      ST_SLEEP:
      begin
        if (wake_wr)
          state_next = ST_SETTLE;
      end
      default:
        state_next = ST_SETTLE;
    endcase
  end

  // the read flag restarts with every wake
  // read flag tracking
  assign read_seen_next = wake_wr ? 1'b0 :
                          (read_done | read_seen_reg);

  // power state field follows the sleep and drops back on wake
  // self-clearing state
  assign power_state_select_next = sleep_req ? pm_state_e'(wd_mode) :
                        wake_wr   ? PM_D0 : power_state_select_reg;

  // phy reset starts only from low, then runs a fixed count
  // ignore while high
  wire phy_start = pm_wr & wd[`PHY_RESET_REQUEST_BIT] & ~phy_reset_request_reg;

  // timed phy reset
  // the bit stands while any count is left, so the phy sees the
  // whole count of cycles and never one short of the minimum
  assign phy_reset_request_next = phy_start | (phy_cnt_next != '0);
  assign phy_cnt_next = phy_start ? PW'(PHY_CYC) :
                        (phy_cnt_reg != '0) ? phy_cnt_reg - 1'b1 :
                        phy_cnt_reg;

  // qualified wake events, independent of the pin enable
  // wake frame interrupt
  wire wf_hit = wake_frame_event & wf_en_reg;
  wire ed_hit = energy_detect_event & energy_detect_event_enable_reg;

  // sticky causes; a new event beats a clear in the same cycle
  assign wups_next = (wups_reg & ~(pm_wr ? wd_wups : 2'b00)) |
                     {wf_hit, ed_hit};

  // long pulse for the pulsed pin mode
  logic pulse_active;

  wake_pulse_timer #(
    .CYCLES (WAKE_PULSE_CYCLES)
  ) u_pulse (
    .clk    (clk),
    .arst_n (arst_n),
    .start  (wf_hit | ed_hit),
    .active (pulse_active)
  );

  // pin is active only with its enable set
  // wake frame to pin
  wire pin_active = out_en_reg &
                    (pulse_sel_reg ? pulse_active : (|wups_reg));

  // push-pull honours polarity; open-drain pulls low and floats idle
  // buffer type
  assign wout_next = drv_type_reg ? (pol_reg ? pin_active : ~pin_active)
                                  : 1'b0;
  assign woe_next  = drv_type_reg | pin_active;

  // read views; unlisted bits stay zero
  // status dwords used
  wire [31:0] rd_tx = {8'h00, txs_reg, txd_reg};

  wire [31:0] rd_pm = {18'h00000, power_state_select_reg, 1'b0, phy_reset_request_reg,
                       wf_en_reg, energy_detect_event_enable_reg, 1'b0, drv_type_reg,
                       wups_reg, pulse_sel_reg, pol_reg, out_en_reg,
                       ready};

  // only the tx info register refuses access while unready; the control
  // and wake test registers stay open in every power state
  // readable while asleep
  wire acc_err = ~mapped | (hit_tx & ~ready);

  // answer is formed in the setup cycle, so pready rises in the
  // first access cycle: no wait states, at the cost of reading
  // state one cycle early
  always_comb
  begin
    rsp_next        = '0;
    rsp_next.pready = setup;
    if (setup)
    begin
      rsp_next.pslverr = acc_err;
      if (!acc_err && !apb_req.pwrite)
        rsp_next.prdata = hit_tx ? rd_tx : hit_pm ? rd_pm : 32'h0;
    end
  end

  // sequencer and bus registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg     <= ST_SETTLE;
      rdy_cnt_reg   <= '0;
      read_seen_reg <= 1'b0;
      rsp_reg       <= '0;
      rdy_out_reg   <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      rdy_cnt_reg   <= rdy_cnt_next;
      read_seen_reg <= read_seen_next;
      rsp_reg       <= rsp_next;
      rdy_out_reg   <= (state_next == ST_READY);
    end
  end

  // fifo level snapshot, sampled every cycle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      txs_reg <= `TXS_USED_RST;
      txd_reg <= `TXD_FREE_RST;
    end
    else
    begin
      txs_reg <= tx_status_used_dwords;
      txd_reg <= tx_data_free_bytes;
    end
  end

  // power state, phy reset and wake causes
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      power_state_select_reg <= PM_D0;
      phy_reset_request_reg <= 1'b0;
      phy_cnt_reg <= '0;
      wups_reg    <= 2'b00;
    end
    else
    begin
      power_state_select_reg <= power_state_select_next;
      phy_reset_request_reg <= phy_reset_request_next;
      phy_cnt_reg <= phy_cnt_next;
      wups_reg    <= wups_next;
    end
  end

  // plain read/write control bits
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wf_en_reg     <= 1'b0;
      energy_detect_event_enable_reg     <= 1'b0;
      drv_type_reg  <= 1'b0;
      pulse_sel_reg <= 1'b0;
      pol_reg       <= 1'b0;
      out_en_reg    <= 1'b0;
    end
    else if (pm_wr)
    begin
      wf_en_reg     <= wd[`WF_EN_BIT];
      energy_detect_event_enable_reg     <= wd[`ENERGY_DETECT_EVENT_ENABLE_BIT];
      drv_type_reg  <= wd[`DRV_TYPE_BIT];
      pulse_sel_reg <= wd[`PULSE_SEL_BIT];
      pol_reg       <= wd[`POL_BIT];
      out_en_reg    <= wd[`OUT_EN_BIT];
    end
  end

  // output flops for interrupt and pin
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      int_reg  <= 1'b0;
      wout_reg <= 1'b0;
      woe_reg  <= 1'b0;
    end
    else
    begin
      int_reg  <= |wups_next;
      wout_reg <= wout_next;
      woe_reg  <= woe_next;
    end
  end

  // ports straight from flops
  assign apb_rsp              = rsp_reg;
  assign phy_reset            = phy_reset_request_reg;
  assign power_state          = power_state_select_reg;
  assign device_ready         = rdy_out_reg;
  assign wake_event_interrupt = int_reg;
  assign wake_event_output    = wout_reg;
  assign wake_event_output_oe = woe_reg;
endmodule // pm_regs

// file: hw/pm_regs_defs.svh
// offsets, field positions, reset values and timing counts
`ifndef PM_REGS_DEFS_SVH
`define PM_REGS_DEFS_SVH

// register bus address width in bits
`define APB_AW 8

// register byte offsets
`define TX_INFO_OFFS 8'h80
`define PM_CTRL_OFFS 8'h84
`define BYTE_ORDER_TEST_OFFS 8'h90

// transmit information fields
`define TXS_USED_LSB 16
`define TXS_USED_W 8
`define TXD_FREE_W 16
`define TXS_USED_RST 8'h00
`define TXD_FREE_RST 16'h1200

// power management control fields
`define POWER_STATE_SELECT_LSB 12
`define PHY_RESET_REQUEST_BIT 10
`define WF_EN_BIT 9
`define ENERGY_DETECT_EVENT_ENABLE_BIT 8
`define DRV_TYPE_BIT 6
`define WUPS_LSB 4
`define PULSE_SEL_BIT 3
`define POL_BIT 2
`define OUT_EN_BIT 1
`define READY_BIT 0

// timing: clock rate and printed times
`define CLK_MHZ 10
`define PHY_RESET_REQUEST_US 100
`define PHY_RESET_REQUEST_CYC (`PHY_RESET_REQUEST_US * `CLK_MHZ)
`define WAKE_PULSE_MS 50
`define WAKE_PULSE_CYC (`WAKE_PULSE_MS * 1000 * `CLK_MHZ)
`define READY_CYC 16

`endif

// file: hw/pm_regs_pkg.sv
// types shared by the power management register bank
package pm_regs_pkg;
  `include "pm_regs_defs.svh"

  // apb request from the master
  typedef struct packed {
    logic [`APB_AW-1:0] paddr;
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [31:0]        pwdata;
  } apb_req_s;

  // apb answer to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_s;

  // power state encodings
  typedef enum logic [1:0] {
    PM_D0 = 2'b00,
    PM_D1 = 2'b01,
    PM_D2 = 2'b10
  } pm_state_e;

  // readiness sequencer states
  typedef enum logic [1:0] {
    ST_SETTLE = 2'b00,
    ST_READY  = 2'b01,
    ST_SLEEP  = 2'b10
  } rdy_state_e;
endpackage

// file: hw/wake_pulse_timer.sv
// one-shot timer that stretches a wake event into a long pulse
`timescale 1ns/100ps
module wake_pulse_timer #(
  parameter int unsigned CYCLES = 500000
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // trigger and pulse
  input  wire logic start,
  output logic      active
);
  localparam int unsigned W = $clog2(CYCLES + 1);

  logic [W-1:0] cnt_reg;  // cycles left in the pulse
  logic [W-1:0] cnt_next;

  // a new event restarts the full length
  assign cnt_next = start ? CYCLES[W-1:0] :
                    (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
  assign active   = (cnt_reg != '0);

  // countdown register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_next;
  end
endmodule // wake_pulse_timer

// file: verif/pm_regs_checker.sv
// concurrent checks on the power management register bank ports
`timescale 1ns/100ps
`include "pm_regs_defs.svh"
module pm_regs_checker #(
  parameter int unsigned WAKE_PULSE_CYCLES = 20,
  parameter int unsigned READY_CYCLES      = 4
) (
  // clock and reset
  input wire logic                  clk,
  input wire logic                  arst_n,
  // register bus
  input wire pm_regs_pkg::apb_req_s apb_req,
  input wire pm_regs_pkg::apb_rsp_s apb_rsp,
  // fifo levels and wake detectors
  input wire logic [7:0]            tx_status_used_dwords,
  input wire logic [15:0]           tx_data_free_bytes,
  input wire logic                  wake_frame_event,
  input wire logic                  energy_detect_event,
  // control and wake outputs
  input wire logic                  phy_reset,
  input wire logic [1:0]            power_state,
  input wire logic                  device_ready,
  input wire logic                  wake_event_interrupt,
  input wire logic                  wake_event_output,
  input wire logic                  wake_event_output_oe
);
  import pm_regs_pkg::*;
  logic [10:0] phy_cnt; // cycles the phy reset has stood high
  wire         setup = apb_req.psel & ~apb_req.penable;
  wire         rd    = setup & ~apb_req.pwrite;
  wire         wr    = apb_req.psel & apb_req.penable & apb_req.pwrite
                       & apb_rsp.pready;
  wire   [7:0] a     = apb_req.paddr;
  // counts high time; a reset cut short falls early and fails the fall check
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      phy_cnt <= 11'h0;
    else
      phy_cnt <= phy_reset ? phy_cnt + 11'h1 : 11'h0;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  pm_read_a: assert property (
    rd && a == 8'h84 |=> apb_rsp.pready && !apb_rsp.pslverr)
    else $error("power control read refused");
  tx_info_a: assert property (
    rd && a == 8'h80 && device_ready && $stable(tx_data_free_bytes)
    && $stable(tx_status_used_dwords) |=> apb_rsp.prdata ==
    {8'h00, $past(tx_status_used_dwords), $past(tx_data_free_bytes)})
    else $error("tx info read wrong");
  rsvd_zero_a: assert property (
    rd && a == 8'h84 |=> apb_rsp.prdata[31:14] == 18'h0
    && apb_rsp.prdata[11] == 1'b0 && apb_rsp.prdata[7] == 1'b0)
    else $error("reserved bits not zero");
  ready_bit_a: assert property (
    rd && a == 8'h84 |=> apb_rsp.prdata[0] == $past(device_ready))
    else $error("ready bit differs from flag");
  no_mode3_a: assert property (
    wr && a == 8'h84 && apb_req.pwdata[13:12] == 2'b11
    && power_state == 2'b00 |=> power_state == 2'b00)
    else $error("reserved power state taken");
  wake_wr_a: assert property (
    wr && a == 8'h90 && power_state != 2'b00 |=> power_state == 2'b00)
    else $error("wake write did not wake");
  phy_len_a: assert property (
    $fell(phy_reset) |-> phy_cnt == `PHY_RESET_REQUEST_CYC)
    else $error("phy reset length wrong");
  phy_hold_a: assert property (
    phy_reset && wr && a == 8'h84 && phy_cnt < 11'd900 |=> phy_reset)
    else $error("phy reset write not ignored");
  irq_cause_a: assert property (
    $rose(wake_event_interrupt)
    |-> $past(wake_frame_event || energy_detect_event))
    else $error("interrupt without event");
  sleep_rdy_a: assert property (
    power_state != 2'b00 ##1 power_state != 2'b00 |-> !device_ready)
    else $error("ready while asleep");
  // main scenarios seen
  phy_done_c: cover property ($fell(phy_reset));
  wake_c: cover property (wr && a == 8'h90 && power_state != 2'b00);
  irq_c: cover property ($rose(wake_event_interrupt));
endmodule // pm_regs_checker

bind pm_regs pm_regs_checker #(
  .WAKE_PULSE_CYCLES(WAKE_PULSE_CYCLES), .READY_CYCLES(READY_CYCLES)
) chk_u (
  .clk(clk), .arst_n(arst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .tx_status_used_dwords(tx_status_used_dwords),
  .tx_data_free_bytes(tx_data_free_bytes),
  .wake_frame_event(wake_frame_event),
  .energy_detect_event(energy_detect_event), .phy_reset(phy_reset),
  .power_state(power_state), .device_ready(device_ready),
  .wake_event_interrupt(wake_event_interrupt),
  .wake_event_output(wake_event_output),
  .wake_event_output_oe(wake_event_output_oe));

// file: verif/apb_host_model.sv
// apb host model standing on the processor side of the bank
`timescale 1ns/100ps
module apb_host_model (
  // clock
  input  wire logic                  clk,
  // register bus
  output pm_regs_pkg::apb_req_s      req,
  input  wire pm_regs_pkg::apb_rsp_s rsp,
  // answer never came
  output logic                       hang
);
  import pm_regs_pkg::*;
  // idle bus at time zero
  initial
  begin
    req  = '0;
    hang = 1'b0;
  end
  // no data pushes
  // this host never feeds the tx data fifo, so it cannot overfill it
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 16);
    hang <= (rsp.pready !== 1'b1);
    // released lines show the inverse so stale values cannot pass
    req <= '{paddr: ~a, psel: 1'b0, penable: 1'b0, pwrite: ~w,
             pwdata: ~d};
    // one idle edge, so a following call never drives req twice
    // in the same time step
    @(posedge clk);
  endtask
endmodule // apb_host_model

// file: verif/test_tx_fifo_info_and_power_mgmt_regs.sv
// self-checking bench for the power management register bank
`timescale 1ns/100ps
module test_tx_fifo_info_and_power_mgmt_regs;
  import pm_regs_pkg::*;
  localparam int unsigned WPC = 20; // short wake pulse
  logic        clk, arst_n, wf, ed, phy, rdy, irq, wout, woe, hang;
  logic [7:0]  used;
  logic [15:0] free;
  logic [1:0]  pst;
  apb_req_s    req;
  apb_rsp_s    rsp;
  logic [32:0] exp_q[$]; // expected {pslverr, prdata} per read
  int          err_count, num_checks;
  pm_regs #(.WAKE_PULSE_CYCLES(WPC), .READY_CYCLES(4)) dut_u (
    .clk(clk), .arst_n(arst_n), .apb_req(req), .apb_rsp(rsp),
    .tx_status_used_dwords(used), .tx_data_free_bytes(free),
    .wake_frame_event(wf), .energy_detect_event(ed),
    .phy_reset(phy), .power_state(pst), .device_ready(rdy),
    .wake_event_interrupt(irq), .wake_event_output(wout),
    .wake_event_output_oe(woe));
  apb_host_model host_u (.clk(clk), .req(req), .rsp(rsp), .hang(hang));
  task automatic check(input logic [32:0] seen, input logic [32:0] ex);
    num_checks++;
    if (seen !== ex)
    begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, ex);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // reads note their answer first, the monitor compares it
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    host_u.xfer(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d);
  endtask
  // pins as {irq, oe, out}, after letting n edges pass
  task automatic pins(input int n, input logic [2:0] e);
    repeat (n) @(posedge clk);
    check({30'h0, irq, woe, wout}, {30'h0, e});
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 64)
    begin
      @(posedge clk);
      n++;
    end
    if (rdy !== 1'b1)
    begin
      err_count++;
      tally_and_finish();
    end
  endtask
  // read answers stand one cycle, so look at that edge
  always @(posedge clk)
    if (rsp.pready === 1'b1 && req.pwrite === 1'b0)
      check({rsp.pslverr, rsp.prdata},
            exp_q.size() ? exp_q.pop_front() : 33'h1ffffffff);
  always @(posedge hang)
  begin
    err_count++;
    tally_and_finish();
  end
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    int n;
    {arst_n, wf, ed, used} = '0;
    free = 16'h1200;
    {err_count, num_checks} = '0;
    void'($urandom(32'hd175d3fa));
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(8'h84, 33'h0);
    wait_rdy();
    rd(8'h84, 33'h1);
    $display("reset test done");
    repeat (4)
    begin
      used <= 8'($urandom);
      free <= 16'($urandom);
      repeat (2) @(posedge clk);
      rd(8'h80, {1'b0, 8'h00, used, free});
    end
    rd(8'h88, {1'b1, 32'h0});
    $display("tx info test done");
    wr(8'h84, 32'hffff_f3ce);
    rd(8'h84, 33'h34f);
    wf <= 1'b1;
    @(posedge clk);
    wf <= 1'b0;
    pins(2, 3'b111);
    pins(WPC + 2, 3'b110);
    rd(8'h84, 33'h36f);
    wr(8'h84, 32'h37e);
    pins(2, 3'b010);
    wr(8'h84, 32'h304);
    ed <= 1'b1;
    @(posedge clk);
    ed <= 1'b0;
    pins(3, 3'b100);
    wr(8'h84, 32'h306);
    pins(3, 3'b110);
    pins(WPC + 2, 3'b110);
    wr(8'h84, 32'h336);
    pins(2, 3'b000);
    $display("wake test done");
    wr(8'h84, 32'h400);
    wr(8'h84, 32'h400);
    check({32'h0, phy}, 33'h1);
    // edges since the first write, less the loop's closing edge
    n = 3;
    while (phy === 1'b1 && n < 1100)
    begin
      @(posedge clk);
      n++;
    end
    check(33'(n), 33'd1000);
    rd(8'h84, 33'h1);
    $display("phy reset test done");
    for (int m = 1; m < 3; m++)
    begin
      rd(8'h84, 33'h1);
      wr(8'h84, 32'(m) << 12);
      @(posedge clk);
      check({31'h0, pst}, 33'(m));
      rd(8'h84, {1'b0, 18'h0, 2'(m), 12'h0});
      // only the wake register is written while unready
      wr(8'h90, $urandom);
      wait_rdy();
      check({31'h0, pst}, 33'h0);
    end
    // a write before the first read after wake is dropped
    wr(8'h84, 32'h306);
    rd(8'h84, 33'h1);
    wr(8'h84, 32'h306);
    rd(8'h84, 33'h307);
    $display("power state test done");
    repeat (2) @(posedge clk);
    tally_and_finish();
  end
endmodule // test_tx_fifo_info_and_power_mgmt_regs
